// ### qfilt_pkg.sv
// constants, register map and types for the queue threshold and group hash filter
// Operation
// R1 - threshold enabled: set receive flag when buffered frames exceed 8-bit threshold
// R2 - host writes needed transmit space for next frames, in double words
// R3 - space monitor enabled: set space flag when free space covers requested size
// R4 - 64-bit group hash table, used only in hash-perfect filter mode
// R5 - hash index is six top CRC bits over the 48-bit destination address
// R6 - index top two bits pick table word, low four pick bit
// R7 - chosen hash bit one: frame is accepted
// R8 - chosen hash bit zero: frame is discarded
// R9 - receive-all and multicast-with-station bits both set: accept every multicast frame
// R10 - hash words are 16-bit, host read/write, zero after reset
// R11 - receive flag set when a frame is ready; host clears by writing one
// R12 - transmit space flag in status bit 6; host clears by writing one
// R13 - fourth hash word at the next address, zero after reset
// R14 - address CRC uses the Ethernet 32-bit polynomial, bytes in wire order
// R15 - threshold flag raised once when count first rises above threshold
package qfilt_pkg;

	// ============================================================
	// register indices (byte address is four times the index)
	localparam logic [9:0] IDX_RX_THRESHOLD = 10'h19C;
	localparam logic [9:0] IDX_TX_REQ_SIZE = 10'h19E;
	localparam logic [9:0] IDX_HASH0 = 10'h1A0;
	localparam logic [9:0] IDX_HASH1 = 10'h1A2;
	localparam logic [9:0] IDX_HASH2 = 10'h1A4;
	localparam logic [9:0] IDX_HASH3 = 10'h1A6;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h1F0;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h1F1;
	localparam logic [9:0] IDX_RX_QUEUE_CTRL = 10'h1F2;
	localparam logic [9:0] IDX_TX_QUEUE_CTRL = 10'h1F3;
	localparam logic [9:0] IDX_RX_CTRL_ONE = 10'h1F4;

	// ============================================================
	// field positions
	localparam int unsigned RXQ_THR_EN_BIT = 5;
	localparam int unsigned TXQ_MON_BIT = 1;
	localparam int unsigned RX1_HASH_MODE_BIT = 1;
	localparam int unsigned RX1_ALL_BIT = 4;
	localparam int unsigned RX1_MC_STA_BIT = 8;
	localparam int unsigned IRQ_RX_BIT = 13;
	localparam int unsigned IRQ_TXS_BIT = 6;
	localparam int unsigned THR_MSB = 7;

	// ============================================================
	// reset values and counts
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] IRQ_IMPL_MASK = 16'h2040;
	localparam logic [2:0] DA_BYTES = 3'h6;
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

	// ============================================================
	// filter sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_JUDGE = 2'b10
	} filt_state_t;

endpackage : qfilt_pkg

// ### da_crc.sv
// byte-serial Ethernet CRC over the destination address
`timescale 1ns/1ps
module da_crc (
	// clock and reset
	input logic clk,
	input logic rst,
	// byte stream
	input logic start,
	input logic byte_valid,
	input logic [7:0] data_byte,
	// running crc, registered
	output logic [31:0] crc
);
	import qfilt_pkg::*;

	logic [31:0] next_crc;

	// eight serial steps per byte, least significant bit first as on the wire
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[31] ^ d[i]) begin
				r = {r[30:0], 1'b0} ^ CRC_POLY; // [R14]
			end else begin
				r = {r[30:0], 1'b0};
			end
		end
		return r;
	endfunction : crc_byte

	// start reseeds so a first byte never mixes with the previous frame
	always_comb begin
		next_crc = crc;
		if (start && byte_valid) begin
			next_crc = crc_byte(CRC_INIT, data_byte); // [R5]
		end else if (byte_valid) begin
			next_crc = crc_byte(crc, data_byte);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			crc <= CRC_INIT;
		end else begin
			crc <= next_crc;
		end
	end

endmodule : da_crc

// ### queue_threshold_and_hash_filter.sv
// queue threshold interrupts and group hash address filter with apb registers
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module queue_threshold_and_hash_filter (
	// clock and reset
	input logic clk,
	input logic rst,
	// apb slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// queue manager state
	input logic [7:0] rx_frame_count,
	input logic rx_frame_stored,
	input logic [15:0] tx_free_space,
	// destination address stream from the mac
	input logic da_start,
	input logic da_valid,
	input logic [7:0] da_byte,
	// filter verdict
	output logic verdict_valid,
	output logic verdict_accept,
	// interrupt
	output logic irq
);
	import qfilt_pkg::*;

	// ============================================================
	// register state
	logic [15:0] rx_frame_count_threshold;
	logic [15:0] tx_next_request_size;
	logic [15:0] group_hash [4];
	logic [15:0] interrupt_status_reg;
	logic [15:0] irq_mask;
	logic [15:0] receive_queue_control;
	logic [15:0] transmit_queue_control;
	logic [15:0] receive_control_one;
	logic [15:0] next_rx_frame_count_threshold;
	logic [15:0] next_tx_next_request_size;
	logic [15:0] next_group_hash [4];
	logic [15:0] next_interrupt_status_reg;
	logic [15:0] next_irq_mask;
	logic [15:0] next_receive_queue_control;
	logic [15:0] next_transmit_queue_control;
	logic [15:0] next_receive_control_one;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_irq;

	// ============================================================
	// event detection state
	logic above_thr;
	logic space_ok;
	logic next_above_thr;
	logic next_space_ok;
	logic rx_event;
	logic txs_event;

	// ============================================================
	// filter state
	filt_state_t state;
	filt_state_t next_state;
	logic [2:0] byte_cnt;
	logic [2:0] next_byte_cnt;
	logic is_group;
	logic next_is_group;
	logic next_verdict_valid;
	logic next_verdict_accept;
	logic [31:0] crc;
	logic [5:0] hash_idx;
	logic hash_bit;

	// ============================================================
	// decode helpers
	logic [9:0] idx;
	logic access_done;
	logic wr_en;
	logic [15:0] wdata;
	logic [7:0] rx_threshold_value;
	logic [15:0] tx_request_size_value;

	assign idx = paddr[11:2];
	// a transfer completes at the edge where the slave shows pready
	assign access_done = psel && penable && pready;
	assign wr_en = access_done && pwrite;
	assign wdata = pwdata[15:0];
	assign rx_threshold_value = rx_frame_count_threshold[THR_MSB:0];
	assign tx_request_size_value = tx_next_request_size; // [R2]

	// ============================================================
	// apb slave: one wait-free access cycle, answer registered in setup
	always_comb begin
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		if (psel && !penable) begin
			next_pready = 1'b1;
			next_prdata = 32'h00000000;
			if (idx == IDX_RX_THRESHOLD) begin
				next_prdata[15:0] = rx_frame_count_threshold;
			end else if (idx == IDX_TX_REQ_SIZE) begin
				next_prdata[15:0] = tx_next_request_size;
			end else if (idx == IDX_HASH0) begin
				next_prdata[15:0] = group_hash[0]; // [R10]
			end else if (idx == IDX_HASH1) begin
				next_prdata[15:0] = group_hash[1];
			end else if (idx == IDX_HASH2) begin
				next_prdata[15:0] = group_hash[2];
			end else if (idx == IDX_HASH3) begin
				next_prdata[15:0] = group_hash[3]; // [R13]
			end else if (idx == IDX_IRQ_STATUS) begin
				next_prdata[15:0] = interrupt_status_reg;
			end else if (idx == IDX_IRQ_MASK) begin
				next_prdata[15:0] = irq_mask;
			end else if (idx == IDX_RX_QUEUE_CTRL) begin
				next_prdata[15:0] = receive_queue_control;
			end else if (idx == IDX_TX_QUEUE_CTRL) begin
				next_prdata[15:0] = transmit_queue_control;
			end else if (idx == IDX_RX_CTRL_ONE) begin
				next_prdata[15:0] = receive_control_one;
			end else begin
				next_pslverr = 1'b1; // unmapped word answers with an error
			end
		end
	end

	// ============================================================
	// register writes; status bits are write-one-to-clear, set wins
	always_comb begin
		next_rx_frame_count_threshold = rx_frame_count_threshold;
		next_tx_next_request_size = tx_next_request_size;
		next_irq_mask = irq_mask;
		next_receive_queue_control = receive_queue_control;
		next_transmit_queue_control = transmit_queue_control;
		next_receive_control_one = receive_control_one;
		for (int i = 0; i < 4; i++) begin
			next_group_hash[i] = group_hash[i];
		end
		next_interrupt_status_reg = interrupt_status_reg;
		if (wr_en) begin
			if (idx == IDX_RX_THRESHOLD) begin
				next_rx_frame_count_threshold = wdata;
			end else if (idx == IDX_TX_REQ_SIZE) begin
				next_tx_next_request_size = wdata; // [R2]
			end else if (idx == IDX_HASH0) begin
				next_group_hash[0] = wdata; // [R10]
			end else if (idx == IDX_HASH1) begin
				next_group_hash[1] = wdata; // [R10]
			end else if (idx == IDX_HASH2) begin
				next_group_hash[2] = wdata; // [R10]
			end else if (idx == IDX_HASH3) begin
				next_group_hash[3] = wdata; // [R13]
			end else if (idx == IDX_IRQ_STATUS) begin
				next_interrupt_status_reg = interrupt_status_reg & ~wdata; // [R11] [R12]
			end else if (idx == IDX_IRQ_MASK) begin
				next_irq_mask = wdata & IRQ_IMPL_MASK;
			end else if (idx == IDX_RX_QUEUE_CTRL) begin
				next_receive_queue_control = wdata;
			end else if (idx == IDX_TX_QUEUE_CTRL) begin
				next_transmit_queue_control = wdata;
			end else if (idx == IDX_RX_CTRL_ONE) begin
				next_receive_control_one = wdata;
			end
		end
		// hardware set is applied after the clear so a same-cycle event survives
		if (rx_event) begin
			next_interrupt_status_reg[IRQ_RX_BIT] = 1'b1; // [R1] [R11]
		end
		if (txs_event) begin
			next_interrupt_status_reg[IRQ_TXS_BIT] = 1'b1; // [R3] [R12]
		end
		next_irq = |(next_interrupt_status_reg & irq_mask);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_frame_count_threshold <= REG_RESET;
			tx_next_request_size <= REG_RESET;
			irq_mask <= REG_RESET;
			receive_queue_control <= REG_RESET;
			transmit_queue_control <= REG_RESET;
			receive_control_one <= REG_RESET;
			interrupt_status_reg <= REG_RESET;
			for (int i = 0; i < 4; i++) begin
				group_hash[i] <= REG_RESET; // [R10] [R13]
			end
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end else begin
			rx_frame_count_threshold <= next_rx_frame_count_threshold;
			tx_next_request_size <= next_tx_next_request_size;
			irq_mask <= next_irq_mask;
			receive_queue_control <= next_receive_queue_control;
			transmit_queue_control <= next_transmit_queue_control;
			receive_control_one <= next_receive_control_one;
			interrupt_status_reg <= next_interrupt_status_reg;
			for (int i = 0; i < 4; i++) begin
				group_hash[i] <= next_group_hash[i];
			end
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			irq <= next_irq;
		end
	end

	// ============================================================
	// queue events: threshold and space use edge detection so a steady level raises one flag only; with threshold off rx_frame_stored sets the flag directly
	always_comb begin
		next_above_thr = rx_frame_count > rx_threshold_value; // [R1]
		next_space_ok = tx_free_space >= tx_request_size_value; // [R3]
		txs_event = 1'b0;
		rx_event = 1'b0;
		if (receive_queue_control[RXQ_THR_EN_BIT]) begin
			rx_event = next_above_thr && !above_thr; // [R1] [R15]
		end else begin
			rx_event = rx_frame_stored; // [R11]
		end
		if (transmit_queue_control[TXQ_MON_BIT]) begin
			txs_event = next_space_ok && !space_ok; // [R3]
		end
	end

	// history starts true so leaving reset above a level raises nothing spurious
	always_ff @(posedge clk) begin
		if (rst) begin
			above_thr <= 1'b1;
			space_ok <= 1'b1;
		end else begin
			above_thr <= next_above_thr;
			space_ok <= next_space_ok;
		end
	end

	// ============================================================
	// destination address crc
	da_crc u_crc (
		.clk(clk),
		.rst(rst),
		.start(da_start),
		.byte_valid(da_valid),
		.data_byte(da_byte),
		.crc(crc)
	);

	assign hash_idx = crc[31:26]; // [R5]
	assign hash_bit = group_hash[hash_idx[5:4]][hash_idx[3:0]]; // [R6]

	// ============================================================
	// filter sequencer: collect six bytes, judge in the following cycle
	always_comb begin
		next_state = state;
		next_byte_cnt = byte_cnt;
		next_is_group = is_group;
		next_verdict_valid = 1'b0;
		next_verdict_accept = verdict_accept;
		if (da_start && da_valid) begin
			// a fresh start always restarts, even mid-address
			next_state = ST_ADDR;
			next_byte_cnt = 3'h1;
			next_is_group = da_byte[0];
		end else begin
			case (state)
				ST_IDLE: begin
					next_state = ST_IDLE;
				end
				ST_ADDR: begin
					if (da_valid) begin
						next_byte_cnt = byte_cnt + 3'h1;
					end
					if (da_valid && (byte_cnt + 3'h1 == DA_BYTES)) begin
						next_state = ST_JUDGE;
					end
				end
				ST_JUDGE: begin
					next_state = ST_IDLE;
					next_verdict_valid = 1'b1;
					if (!is_group || !receive_control_one[RX1_HASH_MODE_BIT]) begin
						next_verdict_accept = 1'b1; // [R4]
					end else if (receive_control_one[RX1_ALL_BIT]
							&& receive_control_one[RX1_MC_STA_BIT]) begin
						next_verdict_accept = 1'b1; // [R9]
					end else if (hash_bit) begin
						next_verdict_accept = 1'b1; // [R7]
					end else begin
						next_verdict_accept = 1'b0; // [R8]
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			byte_cnt <= 3'h0;
			is_group <= 1'b0;
			verdict_valid <= 1'b0;
			verdict_accept <= 1'b0;
		end else begin
			state <= next_state;
			byte_cnt <= next_byte_cnt;
			is_group <= next_is_group;
			verdict_valid <= next_verdict_valid;
			verdict_accept <= next_verdict_accept;
		end
	end

endmodule : queue_threshold_and_hash_filter

// ### qfilt_chk.sv
// port assertions for the queue threshold and hash filter
`timescale 1ns/1ps
module qfilt_chk
	import qfilt_pkg::*;
(
	// clock and reset
	input logic clk,
	input logic rst,
	// apb
	input logic psel,
	input logic penable,
	input logic [11:0] paddr,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	// filter
	input logic da_start,
	input logic da_valid,
	input logic [7:0] da_byte,
	input logic verdict_valid,
	input logic verdict_accept,
	input logic irq
);
	// ============================================================
	// group bit of the address under judgement
	logic grp_q;
	logic next_grp;
	always_comb begin
		next_grp = da_start && da_valid ? da_byte[0] : grp_q;
	end
	// registered so the verdict is compared with the frame that caused it
	always_ff @(posedge clk) begin
		grp_q <= rst ? 1'b0 : next_grp;
	end
	function automatic logic mapped(input logic [9:0] i);
		return i inside {IDX_RX_THRESHOLD, IDX_TX_REQ_SIZE, IDX_HASH0, IDX_HASH1, IDX_HASH2,
			IDX_HASH3, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_RX_QUEUE_CTRL, IDX_TX_QUEUE_CTRL,
			IDX_RX_CTRL_ONE};
	endfunction : mapped
	// ============================================================
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence answer_s;
		psel && penable && pready;
	endsequence
	apb_answer_a: assert property (setup_s |=> answer_s)
		else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	slverr_map_a: assert property (pready |-> pslverr == !mapped(paddr[11:2]))
		else $error("error response does not match map");
	upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	verdict_pulse_a: assert property (verdict_valid |=> !verdict_valid)
		else $error("verdict longer than one cycle");
	verdict_delay_a: assert property (verdict_valid |-> $past(da_valid, 2))
		else $error("verdict not two cycles after last byte");
	unicast_pass_a: assert property (verdict_valid && !grp_q |-> verdict_accept)
		else $error("individual address rejected");
	reset_quiet_a: assert property ($fell(rst) |-> !irq && !verdict_valid && !pready)
		else $error("outputs active after reset");
endmodule : qfilt_chk
bind queue_threshold_and_hash_filter qfilt_chk chk_u (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.da_start(da_start), .da_valid(da_valid), .da_byte(da_byte),
	.verdict_valid(verdict_valid), .verdict_accept(verdict_accept), .irq(irq));

// ### qfilt_mac.sv
// mac side model that streams destination addresses
`timescale 1ns/1ps
module qfilt_mac (
	// clock
	input logic clk,
	// address stream
	output logic da_start,
	output logic da_valid,
	output logic [7:0] da_byte
);
	// ============================================================
	// idle lines at time zero
	initial begin
		da_start = 1'b0;
		da_valid = 1'b0;
		da_byte = 8'h00;
	end
	// six bytes in wire order, first byte first
	task automatic send(input logic [47:0] da);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			da_start <= (i == 0);
			da_valid <= 1'b1;
			da_byte <= da[47 - 8 * i -: 8];
		end
		@(posedge clk);
		da_start <= 1'b0;
		da_valid <= 1'b0;
		da_byte <= ~da[7:0]; // released byte lane shows no stale value
	endtask : send
endmodule : qfilt_mac

// ### tb_queue_threshold_and_hash_filter.sv
// self-checking testbench for the queue threshold and hash filter
`timescale 1ns/1ps
module tb_queue_threshold_and_hash_filter;
	import qfilt_pkg::*;
	// ============================================================
	// signals
	logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
	logic rx_frame_stored, da_start, da_valid, verdict_valid, verdict_accept;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] rx_frame_count, da_byte;
	logic [15:0] tx_free_space;
	logic [47:0] da;
	logic [5:0] k;
	logic [9:0] hidx [4] = '{IDX_HASH0, IDX_HASH1, IDX_HASH2, IDX_HASH3};
	logic [9:0] regs [6] = '{IDX_RX_THRESHOLD, IDX_TX_REQ_SIZE, IDX_HASH0, IDX_HASH1,
		IDX_HASH2, IDX_HASH3};
	int errors, cmp_count, cyc;
	queue_threshold_and_hash_filter dut_u (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_frame_count(rx_frame_count),
		.rx_frame_stored(rx_frame_stored), .tx_free_space(tx_free_space),
		.da_start(da_start), .da_valid(da_valid), .da_byte(da_byte),
		.verdict_valid(verdict_valid), .verdict_accept(verdict_accept), .irq(irq));
	qfilt_mac mac_u (.clk(clk), .da_start(da_start), .da_valid(da_valid), .da_byte(da_byte));
	// ============================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, wd};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd_chk(input logic [9:0] idx, input logic [15:0] exp);
		apb(1'b0, idx, 16'h0000);
		check(rd, {16'h0000, exp});
	endtask : rd_chk
	// reference hash: msb-shift crc, bits lsb first in wire order
	function automatic logic [5:0] hash_of(input logic [47:0] a);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 47; i >= 0; i -= 8) begin
			for (int b = 0; b < 8; b++) begin
				c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i - 7 + b]) ? CRC_POLY : 32'h0);
			end
		end
		return c[31:26];
	endfunction : hash_of
	task automatic judge(input logic exp);
		int n;
		n = 0;
		mac_u.send(da);
		while (verdict_valid !== 1'b1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		// a missing verdict counts as a mismatch, not only a wrong one
		check({verdict_valid, verdict_accept}, {1'b1, exp});
	endtask : judge
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	// ============================================================
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// a hang costs one mismatch and ends the run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			errors++;
			wrap_up();
		end
	end
	// ============================================================
	// scenarios
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		{rx_frame_stored, rx_frame_count, tx_free_space} = 25'h0;
		{errors, cmp_count, cyc} = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (regs[i]) rd_chk(regs[i], 16'h0000);
		apb(1'b1, 10'h1FF, 16'hFFFF);
		check(err, 1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, hidx[i], 16'hA5C3 ^ 16'(i));
			rd_chk(hidx[i], 16'hA5C3 ^ 16'(i));
			apb(1'b1, hidx[i], 16'h0000);
		end
		// group address through the hash table
		apb(1'b1, IDX_RX_CTRL_ONE, 16'h0002);
		da = 48'h01005E0000FB;
		k = hash_of(da);
		judge(1'b0);
		apb(1'b1, hidx[k[5:4]], 16'h0001 << k[3:0]);
		judge(1'b1);
		apb(1'b1, hidx[k[5:4]], ~(16'h0001 << k[3:0]));
		judge(1'b0);
		apb(1'b1, IDX_RX_CTRL_ONE, 16'h0012);
		judge(1'b0);
		apb(1'b1, IDX_RX_CTRL_ONE, 16'h0112);
		judge(1'b1);
		apb(1'b1, IDX_RX_CTRL_ONE, 16'h0000);
		judge(1'b1);
		// individual address in hash mode with an empty table still passes
		apb(1'b1, hidx[k[5:4]], 16'h0000);
		apb(1'b1, IDX_RX_CTRL_ONE, 16'h0002);
		da = 48'h02005E0000FB;
		judge(1'b1);
		// receive threshold: equal does not fire, first crossing fires once
		apb(1'b1, IDX_IRQ_MASK, 16'h2040);
		apb(1'b1, IDX_RX_THRESHOLD, 16'h0003);
		apb(1'b1, IDX_RX_QUEUE_CTRL, 16'h0020);
		rx_frame_count <= 8'h03;
		rd_chk(IDX_IRQ_STATUS, 16'h0000);
		rx_frame_count <= 8'h04;
		rd_chk(IDX_IRQ_STATUS, 16'h2000);
		check(irq, 1);
		apb(1'b1, IDX_IRQ_STATUS, 16'h2000);
		rd_chk(IDX_IRQ_STATUS, 16'h0000);
		// threshold off: a single stored frame raises the receive flag
		apb(1'b1, IDX_RX_QUEUE_CTRL, 16'h0000);
		rx_frame_stored <= 1'b1;
		@(posedge clk);
		rx_frame_stored <= 1'b0;
		rd_chk(IDX_IRQ_STATUS, 16'h2000);
		apb(1'b1, IDX_IRQ_STATUS, 16'h2000);
		rd_chk(IDX_IRQ_STATUS, 16'h0000);
		// transmit space: one short, then enough, masked, cleared
		apb(1'b1, IDX_TX_REQ_SIZE, 16'h0100);
		apb(1'b1, IDX_TX_QUEUE_CTRL, 16'h0002);
		tx_free_space <= 16'h00FF;
		rd_chk(IDX_IRQ_STATUS, 16'h0000);
		tx_free_space <= 16'h0100;
		rd_chk(IDX_IRQ_STATUS, 16'h0040);
		apb(1'b1, IDX_IRQ_MASK, 16'h0000);
		repeat (2) @(posedge clk);
		check(irq, 0);
		apb(1'b1, IDX_IRQ_STATUS, 16'h0040);
		rd_chk(IDX_IRQ_STATUS, 16'h0000);
		wrap_up();
	end
endmodule : tb_queue_threshold_and_hash_filter
